// File: include/tcd_pkg.sv
// package: register map, field layout and reset values of the timer block
package tcd_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] COUNT_OFS = 8'h04;
   localparam logic [7:0] PERIOD_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0c;
   // control field positions
   localparam int MODE_LSB = 0;
   localparam int DIV_LSB = 2;
   localparam int CLEAR_POS = 4;
   // reset values
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   localparam logic [15:0] PERIOD_RST = 16'hffff;
   localparam logic [15:0] COUNT_RST = 16'h0000;
   localparam logic [2:0] DIVCNT_RST = 3'h0;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // counting modes
   typedef enum logic [1:0] {MODE_STOP, MODE_UP, MODE_CONT, MODE_UPDOWN} tcd_mode_e;
endpackage

// File: include/tcd_ctl_if.sv
// interface: control bundle from the register file to one timer core
`timescale 1ns/10ps
interface tcd_ctl_if;
   logic [1:0] mode;
   logic [1:0] divSel;
   logic [15:0] period;
   logic clearPulse;
   logic [15:0] count;
   logic down;
   modport regs (output mode, output divSel, output period, output clearPulse,
      input count, input down);
   modport core (input mode, input divSel, input period, input clearPulse,
      output count, output down);
endinterface

// File: rtl/tcd_timer_core.sv
// one 16-bit timer: input divider, counter and latched direction
`timescale 1ns/10ps
module tcd_timer_core
(
   input wire logic clk_sys,
   input wire logic rst,
   tcd_ctl_if.core ctl
);
   logic [2:0] divCnt_q;
   logic [15:0] count_q;
   logic down_q;
   logic [2:0] divMax;
   logic tick;
   logic running;
   logic atTop;

   // divide ratio 1,2,4,8; the ratio itself is never touched by clear
   assign divMax = (3'h1 << ctl.divSel) - 3'h1;
   assign tick = (divCnt_q == divMax);
   assign running = (ctl.mode != tcd_pkg::MODE_STOP);
   assign atTop = (count_q == ctl.period);

   // divider counter, restarted by the clear pulse
   always_ff @(posedge clk_sys)
   begin
      if (rst || ctl.clearPulse)
         divCnt_q <= tcd_pkg::DIVCNT_RST;
      else if (running)
         divCnt_q <= tick ? tcd_pkg::DIVCNT_RST : divCnt_q + 3'h1;
   end

   // counter and direction latch; direction is held while stopped
   always_ff @(posedge clk_sys)
   begin
      if (rst || ctl.clearPulse)
      begin
         count_q <= tcd_pkg::COUNT_RST;
         down_q <= 1'b0;
      end
      else if (running && tick)
      begin
         unique case (ctl.mode)
            tcd_pkg::MODE_UP: count_q <= atTop ? 16'h0000 : count_q + 16'h0001;
            tcd_pkg::MODE_CONT: count_q <= count_q + 16'h0001;
            tcd_pkg::MODE_UPDOWN:
            begin
               if (!down_q && atTop)
               begin
                  down_q <= 1'b1;
                  count_q <= count_q - 16'h0001;
               end
               else if (down_q && count_q == 16'h0000)
               begin
                  down_q <= 1'b0;
                  count_q <= 16'h0001;
               end
               else
                  count_q <= down_q ? count_q - 16'h0001 : count_q + 16'h0001;
            end
            default: count_q <= count_q;
         endcase
      end
   end

   assign ctl.count = count_q;
   assign ctl.down = down_q;
endmodule // tcd_timer_core

// File: rtl/tcd_timer_pair.sv
// top: axi4-lite register file over two identical timers
`timescale 1ns/10ps
//--------------------------------------------------------------
// How it works
// - setting a timer's clear bit zeroes its count register.
// - clear restarts the divider's internal count but keeps the divide ratio.
// - clear resets the latched direction so counting next goes upward.
// - the direction is held while halted and resumes unchanged without a clear.
// - the clear bit self-clears and always reads back as zero.
//--------------------------------------------------------------
module tcd_timer_pair
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   //--------------------------------------------------------------
   // write channel capture
   //--------------------------------------------------------------
   logic awHave_q;
   logic wHave_q;
   logic [7:0] awAddr_q;
   logic [31:0] wData_q;
   logic [3:0] wStrb_q;
   logic doWrite;
   logic [31:0] ctrl_q [2];
   logic [15:0] period_q [2];
   logic clr_q [2];
   tcd_ctl_if ctl[2] ();

   logic awHave_d;
   logic wHave_d;
   logic bValid_d;

   // slot and response state one edge ahead, so the readies can come from flops
   assign doWrite = awHave_q && wHave_q && !s_axi_bvalid;
   assign awHave_d = (s_axi_awvalid && s_axi_awready) || (awHave_q && !doWrite);
   assign wHave_d = (s_axi_wvalid && s_axi_wready) || (wHave_q && !doWrite);
   assign bValid_d = doWrite || (s_axi_bvalid && !s_axi_bready);

   // address and data taken in either order, held until both present
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         awAddr_q <= 8'h00;
         wData_q <= 32'h00000000;
         wStrb_q <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHave_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         else if (doWrite)
            awHave_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHave_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         else if (doWrite)
            wHave_q <= 1'b0;
         // ready while the slot is empty and no response is waiting
         s_axi_awready <= !awHave_d && !bValid_d;
         s_axi_wready <= !wHave_d && !bValid_d;
      end
   end

   //--------------------------------------------------------------
   // address decode: bit 4 selects the timer, bits 3:2 the register
   //--------------------------------------------------------------
   logic wTmr;
   logic [7:0] wOfs;
   logic wHit;
   logic rTmr;
   logic [7:0] rOfs;
   logic rHit;
   assign wTmr = awAddr_q[4];
   assign wOfs = {3'h0, awAddr_q[3:0]};
   assign wHit = (awAddr_q[7:5] == 3'h0) && (awAddr_q[1:0] == 2'h0);
   assign rTmr = s_axi_araddr[4];
   assign rOfs = {3'h0, s_axi_araddr[3:0]};
   assign rHit = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);

   // write response: unaligned or out-of-range addresses answer slverr
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= tcd_pkg::RESP_OKAY;
      end
      else if (doWrite)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wHit ? tcd_pkg::RESP_OKAY : tcd_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   //--------------------------------------------------------------
   // per-timer registers and cores
   //--------------------------------------------------------------
   genvar t;
   generate
      for (t = 0; t < 2; t++)
      begin : gTmr
         logic sel;
         logic ctrlWr;
         logic perWr;
         assign sel = doWrite && wHit && (wTmr == 1'(t));
         assign ctrlWr = sel && (wOfs == tcd_pkg::CTRL_OFS);
         assign perWr = sel && (wOfs == tcd_pkg::PERIOD_OFS);

         // control and period; clear bit is not stored, only pulsed
         always_ff @(posedge clk_sys)
         begin
            if (rst)
            begin
               ctrl_q[t] <= tcd_pkg::CTRL_RST;
               period_q[t] <= tcd_pkg::PERIOD_RST;
               clr_q[t] <= 1'b0;
            end
            else
            begin
               if (ctrlWr && wStrb_q[0])
                  ctrl_q[t] <= {28'h0000000, wData_q[3:0]};
               if (perWr && wStrb_q[0])
                  period_q[t][7:0] <= wData_q[7:0];
               if (perWr && wStrb_q[1])
                  period_q[t][15:8] <= wData_q[15:8];
               clr_q[t] <= ctrlWr && wStrb_q[0] && wData_q[tcd_pkg::CLEAR_POS];
            end
         end

         assign ctl[t].mode = ctrl_q[t][tcd_pkg::MODE_LSB +: 2];
         assign ctl[t].divSel = ctrl_q[t][tcd_pkg::DIV_LSB +: 2];
         assign ctl[t].period = period_q[t];
         assign ctl[t].clearPulse = clr_q[t];

         tcd_timer_core uCore
         (
            .clk_sys(clk_sys),
            .rst(rst),
            .ctl(ctl[t])
         );
      end
   endgenerate

   //--------------------------------------------------------------
   // read channel: one read at a time, data registered
   //--------------------------------------------------------------
   logic [31:0] rSel [2];
   logic [31:0] rWord;
   // clear bit never stored, so ctrl reads zero there
   assign rSel[0] = (rOfs == tcd_pkg::CTRL_OFS) ? ctrl_q[0] :
      (rOfs == tcd_pkg::COUNT_OFS) ? {16'h0000, ctl[0].count} :
      (rOfs == tcd_pkg::PERIOD_OFS) ? {16'h0000, period_q[0]} :
      {31'h00000000, ctl[0].down};
   assign rSel[1] = (rOfs == tcd_pkg::CTRL_OFS) ? ctrl_q[1] :
      (rOfs == tcd_pkg::COUNT_OFS) ? {16'h0000, ctl[1].count} :
      (rOfs == tcd_pkg::PERIOD_OFS) ? {16'h0000, period_q[1]} :
      {31'h00000000, ctl[1].down};
   assign rWord = rHit ? rSel[rTmr] : 32'h00000000;

   // read response register
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= tcd_pkg::RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_arready <= 1'b0; // one read at a time
         s_axi_rdata <= rWord;
         s_axi_rresp <= rHit ? tcd_pkg::RESP_OKAY : tcd_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
endmodule // tcd_timer_pair

// File: testbench/tcd_timer_pair_asserts.sv
// checker: port-level assertions on the timer pair
`timescale 1ns/10ps
module tcd_timer_pair_asserts
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   //----------------------------------------
   // shadow of what software asked for
   //----------------------------------------
   logic bv_q;
   logic [7:0] wa_q;
   logic [7:0] ra_q;
   logic [5:0] wd_q;
   logic [1:0] clr_q;
   logic [1:0] seen_q;
   logic [1:0] dir_q;
   logic [3:0] ctl_q [2];
   wire wt = wa_q[4];
   wire rt = ra_q[4];
   wire rOk = ra_q[7:5] == 3'h0 && ra_q[1:0] == 2'h0;
   wire rCtl = rOk && ra_q[3:2] == 2'h0;
   wire rCnt = rOk && ra_q[3:2] == 2'h1;
   wire rSt = rOk && ra_q[3:2] == 2'h3;
   wire wNew = s_axi_bvalid && !bv_q;
   wire wCtl = wNew && wa_q[7:5] == 3'h0 && wa_q[3:0] == 4'h0 && wd_q[5];
   // clr_q marks a clear written with the mode field at stop, so the timer must sit at zero
   always_ff @(posedge clk_sys)
   begin
      bv_q <= s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready)
         wa_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
         wd_q <= {s_axi_wstrb[0], s_axi_wdata[4:0]};
      if (s_axi_arvalid && s_axi_arready)
         ra_q <= s_axi_araddr;
      if (wNew)
         seen_q[wt] <= 1'h0;
      if (wCtl)
      begin
         ctl_q[wt] <= wd_q[3:0];
         clr_q[wt] <= wd_q[4] && wd_q[1:0] == 2'h0;
      end
      if (s_axi_rvalid && s_axi_rready && rSt)
      begin
         seen_q[rt] <= 1'h1;
         dir_q[rt] <= s_axi_rdata[0];
      end
      if (rst)
      begin
         bv_q <= 1'h0;
         clr_q <= 2'h0;
         seen_q <= 2'h0;
         ctl_q[0] <= 4'h0;
         ctl_q[1] <= 4'h0;
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_ctlRead;
      s_axi_rvalid && rCtl |-> s_axi_rdata[4:0] == {1'h0, ctl_q[rt]};
   endproperty
   a_ctlRead: assert property (p_ctlRead) else $error("ctrl readback");
   property p_cntZero;
      s_axi_rvalid && rCnt && clr_q[rt] |-> s_axi_rdata == 32'h0;
   endproperty
   a_cntZero: assert property (p_cntZero) else $error("count not cleared");
   property p_dirUp;
      s_axi_rvalid && rSt && clr_q[rt] |-> !s_axi_rdata[0];
   endproperty
   a_dirUp: assert property (p_dirUp) else $error("direction not up");
   property p_dirHeld;
      s_axi_rvalid && rSt && seen_q[rt] && ctl_q[rt][1:0] == 2'h0 |-> s_axi_rdata[0] == dir_q[rt];
   endproperty
   a_dirHeld: assert property (p_dirHeld) else $error("direction lost");
   property p_ctlHigh;
      s_axi_rvalid && rCtl |-> s_axi_rdata[31:4] == 28'h0;
   endproperty
   a_ctlHigh: assert property (p_ctlHigh) else $error("clear bit read back set");
   property p_rdErr;
      s_axi_rvalid && !rOk |-> s_axi_rresp == tcd_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
   endproperty
   a_rdErr: assert property (p_rdErr) else $error("bad read address answered");
   c_clr: cover property (s_axi_rvalid && rCnt && clr_q[rt]);
   c_down: cover property (s_axi_rvalid && rSt && s_axi_rdata[0]);
   c_err: cover property (s_axi_bvalid && s_axi_bresp == tcd_pkg::RESP_SLVERR);
endmodule // tcd_timer_pair_asserts
bind tcd_timer_pair tcd_timer_pair_asserts chk (.*);

// File: testbench/test_timer_clear_and_direction.sv
// testbench: clear and direction of both timers over the register bus
`timescale 1ns/10ps
module test_timer_clear_and_direction;
   typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} tcd_exp_s;
   logic clk_sys = 1'h0;
   logic rst = 1'h1;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
   logic s_axi_bready = 1'h0, s_axi_rready = 1'h0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, b;
   logic [31:0] s_axi_wdata = '0, rv, r;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int failures = 0, n_tests = 0, seed = 30, p;
   tcd_exp_s e;
   tcd_exp_s rq[$];
   logic [1:0] bq[$];
   tcd_timer_pair dut (.*);
   // free-running system clock
   always #12.5 clk_sys = ~clk_sys;
   //----------------------------------------
   // bus master and result checking
   //----------------------------------------
   function automatic logic [1:0] er(input logic [7:0] a);
      return (a[7:5] == 3'h0 && a[1:0] == 2'h0) ? tcd_pkg::RESP_OKAY : tcd_pkg::RESP_SLVERR;
   endfunction
   task automatic chkData(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD rdata exp %h got %h", exp, got);
      end
   endtask
   task automatic chkResp(input logic [1:0] got, input logic [1:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD resp exp %h got %h", exp, got);
      end
   endtask
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bq.push_back(er(a));
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      forever
      begin
         @(posedge clk_sys);
         if (s_axi_awready)
            s_axi_awvalid <= 1'h0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid)
            break;
      end
   endtask
   // masked bits of the read data are checked, the rest ignored
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      rq.push_back('{d, m, er(a)});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      forever
      begin
         @(posedge clk_sys);
         if (s_axi_arready)
            s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid)
            break;
      end
      rv = s_axi_rdata;
   endtask
   // watcher: each response against the oldest note
   always @(posedge clk_sys)
   begin
      if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      begin
         e = rq.pop_front();
         chkData(s_axi_rdata & e.m, e.d);
         chkResp(s_axi_rresp, e.r);
      end
      if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
         chkResp(s_axi_bresp, bq.pop_front());
   end
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog, far beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      stop_test;
   end
   //----------------------------------------
   // scenarios, once per timer
   //----------------------------------------
   initial
   begin
      repeat (10) @(posedge clk_sys);
      rst <= 1'h0;
      s_axi_bready <= 1'h1;
      s_axi_rready <= 1'h1;
      @(posedge clk_sys);
      for (int t = 0; t < 2; t++)
      begin
         b = t[0] ? 8'h10 : 8'h00;
         rd(b, '0, '1);
         rd(b + 8'h08, 32'hffff, '1);
         rd(b + 8'h0c, '0, 32'h1);
         wr(b, 32'h1c);
         rd(b, 32'h0c, 32'h1f);
         p = {$random(seed)} % 8 + 6;
         r = $random(seed);
         wr(b + 8'h08, {r[31:16], p[15:0]});
         rd(b + 8'h08, 32'(p), 32'hffff);
         wr(b, 32'h0f);
         rv = '0;
         for (int i = 0; i < 100 && rv[0] !== 1'h1; i++)
            rd(b + 8'h0c, '0, '0);
         wr(b, 32'h0c);
         repeat (2) rd(b + 8'h0c, 32'h1, 32'h1);
         wr(b, 32'h0f);
         rd(b + 8'h0c, 32'h1, 32'h1);
         wr(b, 32'h0c);
         wr(b, 32'h1c);
         rd(b + 8'h04, '0, '1);
         rd(b + 8'h0c, '0, 32'h1);
         rd(b, 32'h0c, 32'h1f);
         // run briefly so the divider is mid-count when the clear lands
         wr(b, 32'h0f);
         wr(b, 32'h1f);
         rd(b + 8'h04, '0, '1);
         rd(b + 8'h0c, '0, 32'h1);
         rd(b + 8'h0c, '0, 32'h1);
         rd(b + 8'h04, '0, '1);
         rd(b + 8'h04, 32'h1, '1);
         wr(b, 32'h00);
         wr(b + 8'h02, 32'h1f);
         rd(b, '0, 32'h1f);
         rd(8'he0, '0, '1);
         $display("timer %0d tests done", t);
      end
      stop_test;
   end
endmodule // test_timer_clear_and_direction
